// ---- rtl/sia_pkg.sv ----
`default_nettype none
package sia_pkg;
  // ----------------------------------------------------------------
  // Register offsets (word index, byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_STACK_INDEX = 4'h0;
  localparam logic [3:0] REG_STACK_TOP_LOW = 4'h1;
  localparam logic [3:0] REG_STACK_TOP_HIGH = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_CONFIG = 4'h4;
  localparam logic [3:0] REG_FSEL0_LOW = 4'h5;
  localparam logic [3:0] REG_FSEL0_HIGH = 4'h6;
  localparam logic [3:0] REG_FSEL1_LOW = 4'h7;
  localparam logic [3:0] REG_FSEL1_HIGH = 4'h8;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int STATUS_OVER_BIT = 0;
  localparam int STATUS_UNDER_BIT = 1;
  localparam int CONFIG_FAULT_EN_BIT = 0;
  localparam logic [4:0] STACK_INDEX_RESET = 5'h1f;
  localparam logic [4:0] STACK_TOP_ENTRY = 5'h0f;
  localparam int STACK_DEPTH = 16;
  localparam int PC_W = 15;
  // ----------------------------------------------------------------
  // Indirect address map
  // ----------------------------------------------------------------
  localparam logic [15:0] TRAD_LAST = 16'h0fff;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_LAST = 16'h29af;
  localparam logic [15:0] BANK_SIZE = 16'h0080;
  localparam logic [6:0] GP_BLOCK_START = 7'h20;
  localparam logic [6:0] GP_BLOCK_LEN = 7'h50;
  localparam logic [6:0] IND0_OFFSET = 7'h00;
  localparam logic [6:0] IND1_OFFSET = 7'h01;
  localparam logic [7:0] FLASH_WAIT = 8'h01;

  typedef enum logic [1:0] {
    SIA_IDLE  = 2'b00,
    SIA_FLASH = 2'b01,
    SIA_DONE  = 2'b10
  } sia_state_e;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic [14:0] pc;
  } sia_stack_req_s;
endpackage : sia_pkg
`default_nettype wire

// ---- rtl/sia_core.sv ----
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`default_nettype none
// How it works
// - Software picks entry via stack index, reads/writes it via top pair.
// - Stack index is five bits to show out-of-range values.
// - Calls and interrupt entry increment index; returns decrement it.
// - Push increments then stores pc; pop reads pc then decrements.
// - After reset stack empty, index at 0x1f.
// - Fault reset enabled and empty stack: top reads zero.
// - Fault reset disabled and empty stack: top reads entry 0x0f.
// - With fault reset on, overflow/underflow resets and sets flag.
// - Indirect window access goes to file select pointer address.
// - Pointer at indirect window: read zero, write suppressed.
// - Pointer is high and low byte concatenated, 16 bits.
// - Addresses 0x000 to 0xfff map straight to data memory.
// - 0x2000 to 0x29af linearly join 80-byte bank blocks.
// - Unimplemented indirect reads return 0x00.
// - Linear region excludes 16-byte common memory.
// - Pointer msb set: low 15 bits address flash, low byte returned.
// - Indirect writes to flash are ignored.
// - Flash access through indirect path takes one extra cycle.
// - Stack holds 16 entries of 15 bits outside memory spaces.
// - Fault reset off: stack wraps, flags still set.
module sia_core
  import sia_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        stk_push,
  input  wire logic        stk_pop,
  input  wire logic [14:0] stk_pc_in,
  output logic      [14:0] stk_pc_out,
  output logic             stack_fault_reset,
  input  wire logic        ind_req,
  input  wire logic        ind_sel,
  input  wire logic        ind_we,
  input  wire logic [7:0]  ind_wdata,
  output logic             ind_done,
  output logic      [7:0]  ind_rdata,
  output logic             mem_we,
  output logic      [11:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_hit,
  output logic      [14:0] flash_addr,
  input  wire logic [13:0] flash_rdata
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [12:0] lin_map(input logic [15:0] a);
    logic [15:0] off;
    logic [15:0] bank;
    logic [15:0] rem;
    off  = a - LIN_BASE;
    bank = off / {9'h000, GP_BLOCK_LEN};
    rem  = off - bank * {9'h000, GP_BLOCK_LEN};
    lin_map = {bank[5:0], GP_BLOCK_START} + {6'h00, rem[6:0]};
  endfunction : lin_map

  function automatic logic is_window(input logic [15:0] a);
    is_window = (a[15:7] == 9'h000) &&
                (a[6:0] == IND0_OFFSET || a[6:0] == IND1_OFFSET);
  endfunction : is_window

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [14:0] stack_mem [DEPTH];
  logic [4:0]  stack_index;
  logic        stack_over_flag;
  logic        stack_under_flag;
  logic        stack_fault_reset_enable;
  logic [7:0]  fsel_low  [2];
  logic [7:0]  fsel_high [2];
  sia_state_e  state;
  logic [7:0]  wait_cnt;

  logic [4:0]  next_stack_index;
  logic        next_over;
  logic        next_under;
  logic        next_fault;
  logic [14:0] next_pc_out;
  logic        stack_wr;
  logic [3:0]  stack_wr_idx;
  logic [14:0] stack_wr_val;
  logic [31:0] next_rdata;
  logic        next_wait;
  logic        next_enable;
  logic [7:0]  next_fl [2];
  logic [7:0]  next_fh [2];
  sia_state_e  next_state;
  logic [7:0]  next_wait_cnt;
  logic        next_done;
  logic [7:0]  next_ind_rdata;
  logic        next_mem_we;
  logic [11:0] next_mem_addr;
  logic [7:0]  next_mem_wdata;
  logic [14:0] next_flash_addr;

  logic        bus_req;
  logic [3:0]  reg_idx;
  logic [15:0] fsel_ptr;
  logic [14:0] top_val;
  logic        empty;

  assign bus_req = (avs_read || avs_write) && avs_waitrequest;
  assign reg_idx = avs_address[5:2];
  assign fsel_ptr = {fsel_high[ind_sel], fsel_low[ind_sel]};
  assign empty = (stack_index == STACK_INDEX_RESET);
  always_comb begin
    if (empty && stack_fault_reset_enable) begin
      top_val = '0;
    end else begin
      top_val = stack_mem[stack_index[3:0]];
    end
  end

  // ----------------------------------------------------------------
  // Stack and register bus
  // ----------------------------------------------------------------
  always_comb begin
    next_stack_index = stack_index;
    next_over        = stack_over_flag;
    next_under       = stack_under_flag;
    next_fault       = 1'b0;
    next_pc_out      = stk_pc_out;
    stack_wr         = 1'b0;
    stack_wr_idx     = '0;
    stack_wr_val     = '0;
    next_rdata       = avs_readdata;
    next_wait        = 1'b1;
    next_enable      = stack_fault_reset_enable;
    next_fl          = fsel_low;
    next_fh          = fsel_high;
    if (bus_req) begin
      next_wait  = 1'b0;
      next_rdata = '0;
      if (avs_read) begin
        case (reg_idx)
          REG_STACK_INDEX:    next_rdata = {27'h0, stack_index};
          REG_STACK_TOP_LOW:  next_rdata = {24'h0, top_val[7:0]};
          REG_STACK_TOP_HIGH: next_rdata = {25'h0, top_val[14:8]};
          REG_STATUS: next_rdata = {30'h0, stack_under_flag,
                                    stack_over_flag};
          REG_CONFIG: next_rdata = {31'h0, stack_fault_reset_enable};
          REG_FSEL0_LOW:  next_rdata = {24'h0, fsel_low[0]};
          REG_FSEL0_HIGH: next_rdata = {24'h0, fsel_high[0]};
          REG_FSEL1_LOW:  next_rdata = {24'h0, fsel_low[1]};
          REG_FSEL1_HIGH: next_rdata = {24'h0, fsel_high[1]};
          default:        next_rdata = '0;
        endcase
      end else begin
        case (reg_idx)
          REG_STACK_INDEX: next_stack_index = avs_writedata[4:0];
          REG_STACK_TOP_LOW: begin
            stack_wr     = 1'b1;
            stack_wr_idx = stack_index[3:0];
            stack_wr_val = {top_val[14:8], avs_writedata[7:0]};
          end
          REG_STACK_TOP_HIGH: begin
            stack_wr     = 1'b1;
            stack_wr_idx = stack_index[3:0];
            stack_wr_val = {avs_writedata[6:0], top_val[7:0]};
          end
          REG_STATUS: begin
            next_over  = stack_over_flag & avs_writedata[STATUS_OVER_BIT];
            next_under = stack_under_flag & avs_writedata[STATUS_UNDER_BIT];
          end
          REG_CONFIG: next_enable = avs_writedata[CONFIG_FAULT_EN_BIT];
          REG_FSEL0_LOW:  next_fl[0] = avs_writedata[7:0];
          REG_FSEL0_HIGH: next_fh[0] = avs_writedata[7:0];
          REG_FSEL1_LOW:  next_fl[1] = avs_writedata[7:0];
          REG_FSEL1_HIGH: next_fh[1] = avs_writedata[7:0];
          default: ;
        endcase
      end
    end
    // Core events win over a bus write in the same cycle
    if (stk_push) begin
      next_stack_index = stack_index + 5'h01;
      if (stack_index == 5'h0f) begin
        next_over  = 1'b1;
        next_fault = stack_fault_reset_enable;
        next_stack_index = 5'h00;
      end
      stack_wr     = 1'b1;
      stack_wr_idx = next_stack_index[3:0];
      stack_wr_val = stk_pc_in;
    end else if (stk_pop) begin
      next_pc_out      = top_val;
      next_stack_index = stack_index - 5'h01;
      if (empty) begin
        next_under = 1'b1;
        next_fault = stack_fault_reset_enable;
        next_stack_index = 5'h0e;
      end
    end
    if (stack_fault_reset) begin
      next_stack_index = STACK_INDEX_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stack_index              <= STACK_INDEX_RESET;
      stack_over_flag          <= 1'b0;
      stack_under_flag         <= 1'b0;
      stack_fault_reset        <= 1'b0;
      stk_pc_out               <= '0;
      avs_readdata             <= '0;
      avs_waitrequest          <= 1'b1;
      stack_fault_reset_enable <= 1'b1;
      fsel_low                 <= '{default: 8'h00};
      fsel_high                <= '{default: 8'h00};
    end else if (ce) begin
      stack_index              <= next_stack_index;
      stack_over_flag          <= next_over;
      stack_under_flag         <= next_under;
      stack_fault_reset        <= next_fault;
      stk_pc_out               <= next_pc_out;
      avs_readdata             <= next_rdata;
      avs_waitrequest          <= next_wait;
      stack_fault_reset_enable <= next_enable;
      fsel_low                 <= next_fl;
      fsel_high                <= next_fh;
    end
  end

  // Stack array kept without reset, outside memory spaces
  always_ff @(posedge clk) begin
    if (ce && stack_wr) begin
      stack_mem[stack_wr_idx] <= stack_wr_val;
    end
  end

  // ----------------------------------------------------------------
  // Indirect access
  // ----------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_wait_cnt   = wait_cnt;
    next_done       = 1'b0;
    next_ind_rdata  = ind_rdata;
    next_mem_we     = 1'b0;
    next_mem_addr   = mem_addr;
    next_mem_wdata  = mem_wdata;
    next_flash_addr = flash_addr;
    case (state)
      SIA_IDLE: begin
        if (ind_req) begin
          if (fsel_ptr[15]) begin
            next_flash_addr = fsel_ptr[14:0];
            next_wait_cnt   = FLASH_WAIT;
            next_state      = SIA_FLASH; // no write issued
          end else if (is_window(fsel_ptr)) begin
            next_ind_rdata = 8'h00;
            next_done      = 1'b1;
          end else if (fsel_ptr <= TRAD_LAST) begin
            next_mem_addr  = fsel_ptr[11:0];
            next_mem_we    = ind_we;
            next_mem_wdata = ind_wdata;
            next_state     = SIA_DONE;
          end else if (fsel_ptr >= LIN_BASE && fsel_ptr <= LIN_LAST) begin
            next_mem_addr  = 12'(lin_map(fsel_ptr));
            next_mem_we    = ind_we;
            next_mem_wdata = ind_wdata;
            next_state     = SIA_DONE;
          end else begin
            next_ind_rdata = 8'h00;
            next_done      = 1'b1;
          end
        end
      end
      SIA_FLASH: begin
        if (wait_cnt == 8'h00) begin
          next_ind_rdata = flash_rdata[7:0];
          next_done      = 1'b1;
          next_state     = SIA_IDLE;
        end else begin
          next_wait_cnt = wait_cnt - 8'h01;
        end
      end
      SIA_DONE: begin
        next_ind_rdata = mem_hit ? mem_rdata : 8'h00;
        next_done      = 1'b1;
        next_state     = SIA_IDLE;
      end
      default: next_state = SIA_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= SIA_IDLE;
      wait_cnt   <= '0;
      ind_done   <= 1'b0;
      ind_rdata  <= '0;
      mem_we     <= 1'b0;
      mem_addr   <= '0;
      mem_wdata  <= '0;
      flash_addr <= '0;
    end else if (ce) begin
      state      <= next_state;
      wait_cnt   <= next_wait_cnt;
      ind_done   <= next_done;
      ind_rdata  <= next_ind_rdata;
      mem_we     <= next_mem_we;
      mem_addr   <= next_mem_addr;
      mem_wdata  <= next_mem_wdata;
      flash_addr <= next_flash_addr;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_index;
    @(posedge clk) rst |=> stack_index == 5'h1f;
  endproperty
  a_reset_index: assert property (p_reset_index)
    else $error("index not 0x1f after reset");

  property p_push_inc;
    @(posedge clk) disable iff (rst)
      ce && stk_push && stack_index < 5'h0f && !stack_fault_reset
      |=> stack_index == $past(stack_index) + 5'h01;
  endproperty
  a_push_inc: assert property (p_push_inc)
    else $error("push did not increment index");

  property p_pop_dec;
    @(posedge clk) disable iff (rst)
      ce && !stk_push && stk_pop && stack_index != 5'h1f &&
      stack_index != 5'h00 && !stack_fault_reset
      |=> stack_index == $past(stack_index) - 5'h01;
  endproperty
  a_pop_dec: assert property (p_pop_dec)
    else $error("pop did not decrement index");

  property p_push_store;
    @(posedge clk) disable iff (rst)
      ce && stk_push && stack_index < 5'h0f && !stack_fault_reset
      |=> stack_mem[stack_index[3:0]] == $past(stk_pc_in);
  endproperty
  a_push_store: assert property (p_push_store)
    else $error("pushed pc not at new top");

  property p_over_fault;
    @(posedge clk) disable iff (rst)
      ce && stk_push && stack_index == 5'h0f && stack_fault_reset_enable
      |=> stack_fault_reset && stack_over_flag ##1 stack_index == 5'h1f;
  endproperty
  a_over_fault: assert property (p_over_fault)
    else $error("overflow did not reset");

  property p_wrap_flag;
    @(posedge clk) disable iff (rst)
      ce && stk_push && stack_index == 5'h0f && !stack_fault_reset_enable
      |=> stack_over_flag && stack_index == 5'h00 && !stack_fault_reset;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("wrap or flag wrong");

  property p_empty_zero;
    @(posedge clk) disable iff (rst) ce && stk_pop && !stk_push &&
      empty && stack_fault_reset_enable |=> stk_pc_out == 15'h0000;
  endproperty
  a_empty_zero: assert property (p_empty_zero)
    else $error("empty top not zero");

  property p_flash_wait;
    @(posedge clk) disable iff (rst)
      ce && state == SIA_IDLE && ind_req && fsel_ptr[15]
      |=> !ind_done ##1 !ind_done ##1 ind_done && !mem_we;
  endproperty
  a_flash_wait: assert property (p_flash_wait)
    else $error("flash access timing wrong");

  property p_window_zero;
    @(posedge clk) disable iff (rst)
      ce && state == SIA_IDLE && ind_req && is_window(fsel_ptr)
      |=> ind_done && ind_rdata == 8'h00 && !mem_we;
  endproperty
  a_window_zero: assert property (p_window_zero)
    else $error("window self access not suppressed");
endmodule : sia_core
`default_nettype wire

// ---- tb/sia_mem_model.sv ----
`default_nettype none
module sia_mem_model
  import sia_pkg::*;
#(
  parameter logic [11:0] HIT_LIM = 12'hf80
) (
  input  wire logic        clk,
  input  wire logic        mem_we,
  input  wire logic [11:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  output logic             mem_hit,
  input  wire logic [14:0] flash_addr,
  output logic      [13:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // Data memory, top of the page unimplemented
  // ------------------------------------------------------------------
  logic [7:0] ram [4096];
  initial begin
    for (int i = 0; i < 4096; i++) ram[i] = 8'(i) ^ 8'h5a;
  end
  always @(posedge clk) begin
    if (mem_we && mem_hit) ram[mem_addr] <= mem_wdata;
  end
  assign mem_hit = (mem_addr < HIT_LIM);
  // Garbage on a miss, so ignoring the hit flag shows up
  assign mem_rdata = mem_hit ? ram[mem_addr] : ~ram[mem_addr];
  // Flash word, low byte scrambled against the address
  assign flash_rdata = {flash_addr[14:9], flash_addr[7:0] ^ 8'ha5};
endmodule : sia_mem_model
`default_nettype wire

// ---- tb/sia_core_test.sv ----
`default_nettype none
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); \
  end \
end
module sia_core_test
  import sia_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        stk_push = 1'b0;
  logic        stk_pop = 1'b0;
  logic [14:0] stk_pc_in = 15'h0;
  logic [14:0] stk_pc_out;
  logic        stack_fault_reset;
  logic        ind_req = 1'b0;
  logic        ind_sel = 1'b0;
  logic        ind_we = 1'b0;
  logic [7:0]  ind_wdata = 8'h00;
  logic        ind_done;
  logic [7:0]  ind_rdata;
  logic        mem_we;
  logic [11:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic        mem_hit;
  logic [14:0] flash_addr;
  logic [13:0] flash_rdata;
  int          failures = 0;
  int          cmp_count = 0;
  int          fcnt = 0;
  int          wcnt = 0;
  int          n_mem;
  int          n_fl;
  logic [31:0] rd;
  logic [7:0]  bd;
  // Pointer value beside the byte the indirect read must give
  logic [23:0] rows [16] = '{
    {16'h0000, 8'h00}, {16'h0001, 8'h00},
    {16'h0020, 8'h7a}, {16'h0070, 8'h2a},
    {16'h0080, 8'hda}, {16'h07ff, 8'ha5},
    {16'h0fff, 8'h00}, {16'h1000, 8'h00},
    {16'h2000, 8'h7a}, {16'h204f, 8'h35},
    {16'h2050, 8'hfa}, {16'h29af, 8'h35},
    {16'h29b0, 8'h00}, {16'h8000, 8'ha5},
    {16'h8123, 8'h86}, {16'hffff, 8'h5a}
  };

  sia_core #(.DEPTH(STACK_DEPTH)) i_sia_core (
    .clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stk_push(stk_push),
    .stk_pop(stk_pop), .stk_pc_in(stk_pc_in), .stk_pc_out(stk_pc_out),
    .stack_fault_reset(stack_fault_reset), .ind_req(ind_req),
    .ind_sel(ind_sel), .ind_we(ind_we), .ind_wdata(ind_wdata),
    .ind_done(ind_done), .ind_rdata(ind_rdata), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_hit(mem_hit), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata)
  );
  sia_mem_model #(.HIT_LIM(12'hf80)) i_sia_mem_model (
    .clk(clk), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_hit(mem_hit),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata)
  );

  initial begin
    forever #50 clk = ~clk;
  end
  // Counted mid-cycle so a check right after the edge sees the pulse
  always @(negedge clk) begin
    if (stack_fault_reset === 1'b1) fcnt++;
    if (mem_we === 1'b1) wcnt++;
  end
  // ------------------------------------------------------------------
  // Bus and port tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic hang(string s);
    failures++;
    $display("ERROR %s expected 1 seen 0", s);
    report_and_stop();
  endtask : hang
  task automatic bus_wait();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) hang("waitrequest");
  endtask : bus_wait
  task automatic wr(logic [3:0] a, logic [31:0] d);
    avs_address <= {a, 2'b00};
    avs_writedata <= d;
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rdc(string nm, logic [3:0] a, logic [31:0] e);
    avs_address <= {a, 2'b00};
    avs_read <= 1'b1;
    bus_wait();
    rd = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
    `CHK(nm, e, rd)
  endtask : rdc
  task automatic push(logic [14:0] pc);
    stk_pc_in <= pc;
    stk_push <= 1'b1;
    @(posedge clk);
    stk_push <= 1'b0;
    @(posedge clk);
  endtask : push
  task automatic pop(logic c, logic [14:0] e);
    stk_pop <= 1'b1;
    @(posedge clk);
    stk_pop <= 1'b0;
    @(posedge clk);
    if (c) `CHK("stk_pc_out", e, stk_pc_out)
  endtask : pop
  task automatic setp(logic s, logic [15:0] a);
    wr(s ? REG_FSEL1_LOW : REG_FSEL0_LOW, {24'h0, a[7:0]});
    wr(s ? REG_FSEL1_HIGH : REG_FSEL0_HIGH, {24'h0, a[15:8]});
  endtask : setp
  // One access at a time; the next waits for done
  task automatic ind(logic s, logic w, logic [7:0] d, output int n);
    ind_sel <= s;
    ind_we <= w;
    ind_wdata <= d;
    ind_req <= 1'b1;
    @(posedge clk);
    ind_req <= 1'b0;
    for (n = 1; n <= 10; n++) begin
      @(posedge clk);
      if (ind_done === 1'b1) break;
    end
    if (n > 10) hang("ind_done");
    bd = ind_rdata;
    @(posedge clk);
  endtask : ind
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc("index", REG_STACK_INDEX, 32'h1f);
    rdc("config", REG_CONFIG, 32'h1);
    rdc("top_low", REG_STACK_TOP_LOW, 32'h0);
    rdc("top_high", REG_STACK_TOP_HIGH, 32'h0);
    foreach (rows[i]) begin
      setp(i[0], rows[i][23:8]);
      ind(i[0], 1'b0, 8'h00, n_mem);
      `CHK("ind_rdata", rows[i][7:0], bd)
    end
    $display("test map done");
    push(15'h1111);
    push(15'h2222);
    push(15'h3333);
    rdc("index", REG_STACK_INDEX, 32'h2);
    rdc("top_low", REG_STACK_TOP_LOW, 32'h33);
    rdc("top_high", REG_STACK_TOP_HIGH, 32'h33);
    // Index moved only while no push or pop is in flight
    wr(REG_STACK_INDEX, 32'h1);
    rdc("top_low", REG_STACK_TOP_LOW, 32'h22);
    wr(REG_STACK_TOP_LOW, 32'h55);
    wr(REG_STACK_TOP_HIGH, 32'h2a);
    pop(1'b1, 15'h2a55);
    rdc("index", REG_STACK_INDEX, 32'h0);
    pop(1'b1, 15'h1111);
    pop(1'b1, 15'h0);
    `CHK("fault pulses", 1, fcnt)
    rdc("status", REG_STATUS, 32'h1 << STATUS_UNDER_BIT);
    rdc("index", REG_STACK_INDEX, 32'h1f);
    $display("test stack done");
    wr(REG_STATUS, 32'h0);
    wr(REG_CONFIG, 32'h0);
    wr(REG_STACK_INDEX, 32'h0f);
    wr(REG_STACK_TOP_LOW, 32'h9a);
    wr(REG_STACK_TOP_HIGH, 32'h4b);
    wr(REG_STACK_INDEX, 32'h1f);
    rdc("top_low", REG_STACK_TOP_LOW, 32'h9a);
    rdc("top_high", REG_STACK_TOP_HIGH, 32'h4b);
    for (int k = 0; k < 16; k++) push(15'h0100 + 15'(k));
    rdc("index", REG_STACK_INDEX, 32'h0f);
    push(15'h7abc);
    rdc("index", REG_STACK_INDEX, 32'h0);
    rdc("top_high", REG_STACK_TOP_HIGH, 32'h7a);
    rdc("status", REG_STATUS, 32'h1 << STATUS_OVER_BIT);
    pop(1'b1, 15'h7abc);
    pop(1'b1, 15'h010f);
    rdc("index", REG_STACK_INDEX, 32'h0e);
    rdc("status", REG_STATUS, 32'h3);
    `CHK("fault pulses", 1, fcnt)
    wr(REG_STATUS, 32'h0);
    wr(REG_CONFIG, 32'h1);
    wr(REG_STACK_INDEX, 32'h0f);
    push(15'h0abc);
    `CHK("fault pulses", 2, fcnt)
    rdc("status", REG_STATUS, 32'h1 << STATUS_OVER_BIT);
    rdc("index", REG_STACK_INDEX, 32'h1f);
    $display("test wrap done");
    setp(1'b1, 16'h2050);
    ind(1'b1, 1'b1, 8'h3c, n_mem);
    setp(1'b0, 16'h00a0);
    ind(1'b0, 1'b0, 8'h00, n_mem);
    `CHK("linear write", 8'h3c, bd)
    `CHK("mem writes", 1, wcnt)
    setp(1'b0, 16'h8000);
    ind(1'b0, 1'b1, 8'h11, n_fl);
    setp(1'b1, 16'h0001);
    ind(1'b1, 1'b1, 8'h77, n_fl);
    `CHK("mem writes", 1, wcnt)
    ind(1'b0, 1'b0, 8'h00, n_fl);
    `CHK("flash read", 8'ha5, bd)
    `CHK("flash cycles", n_mem + 1, n_fl)
    $display("test indirect done");
    rdc("unmapped", 4'hf, 32'h0);
    wr(4'hf, 32'h5);
    push(15'h0001);
    rdc("fsel0_high", REG_FSEL0_HIGH, 32'h80);
    // Clock enable low: the push must leave no trace
    ce <= 1'b0;
    push(15'h0002);
    ce <= 1'b1;
    rdc("index", REG_STACK_INDEX, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc("index", REG_STACK_INDEX, 32'h1f);
    rdc("fsel0_high", REG_FSEL0_HIGH, 32'h0);
    $display("test reset done");
    report_and_stop();
  end
endmodule : sia_core_test
`default_nettype wire
